// >>> design/scfm_params.svh
// timing constants for the safety cutoff feedback monitor
`ifndef SCFM_PARAMS_SVH
`define SCFM_PARAMS_SVH

`define SCFM_CLK_MHZ          125
`define SCFM_OFF_IGNORE_US    500
`define SCFM_FB_MAX_US        20000
`define SCFM_SKEW_MAX_MS      10000
// glitch filter: off shorter than or equal to 0.5 ms is ignored (least time, round up)
`define SCFM_FILT_CYC         (`SCFM_OFF_IGNORE_US * `SCFM_CLK_MHZ + 1)
// feedback latency bound, for reference (longest time, round down)
`define SCFM_FB_MAX_CYC       (`SCFM_FB_MAX_US * `SCFM_CLK_MHZ)
// skew alarm time in cycles
`define SCFM_SKEW_CYC         (`SCFM_SKEW_MAX_MS * 1000 * `SCFM_CLK_MHZ)
`define SCFM_CNT_W            32

`endif

// >>> design/scfm_pkg.sv
// types for the safety cutoff feedback monitor
package scfm_pkg;
  typedef enum logic [1:0] {SCFM_RUN, SCFM_OPEN, SCFM_WAIT_CLOSE, SCFM_FAULT} scfm_unit_state_t;
endpackage

// >>> design/scfm_link_if.sv
// link between the safety unit and the servo amplifier cutoff logic
`timescale 1ns/1ps
interface scfm_link_if;
  logic safety_input_a_n;
  logic safety_input_b_n;
  logic feedback_monitor_out;
  modport device (input safety_input_a_n, input safety_input_b_n, output feedback_monitor_out);
  modport unit   (output safety_input_a_n, output safety_input_b_n, input feedback_monitor_out);
endinterface

// >>> design/scfm_device.sv
// amplifier side: filters the two cutoff inputs, drives the feedback monitor
//
// Overview of operation
// R1 - feedback on only when both inputs off
// R2 - feedback follows inputs within 20 ms
// R3 - unit drives both off when guard opens
// R4 - unit resets only if feedback on
// R5 - feedback stuck off blocks unit reset
// R6 - both off shows cutoff code, motor held
// R7 - monitor reports each input's actual state
// R8 - missing jumper means no torque, cutoff code
// R9 - host monitors feedback for higher level
// R10 - input on means run, off means cutoff
// R11 - off pulses up to 0.5 ms ignored
// R12 - one-channel off beyond 10 s alarms
// R13 - synchronise, filter inputs before combining
`timescale 1ns/1ps
`include "scfm_params.svh"
module scfm_device
#(
  parameter int unsigned SKEW_CYC = `SCFM_SKEW_CYC,
  parameter int unsigned FILT_CYC = `SCFM_FILT_CYC
)
(
  // clock, reset, enable
  input  wire logic mclk_in,
  input  wire logic sys_rst_in,
  input  wire logic clk_en_in,
  // link
  scfm_link_if.device link,
  // amplifier side
  input  wire logic alarm_clear_in,
  output logic      torque_enable_out,
  output logic      cutoff_display_out,
  output logic [1:0] safety_input_state_monitor_out,
  output logic      input_timing_alarm_out
);

  // ----------------------------------------
  // input synchronisers and off filters
  // ----------------------------------------
  // bit 0 is channel a, bit 1 channel b
  logic      [1:0] raw_in;
  wire logic [1:0] off_reg;
  assign raw_in = {link.safety_input_b_n, link.safety_input_a_n};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_ch
      logic [2:0]             sync_reg;
      logic [`SCFM_CNT_W-1:0] filt_cnt_reg;
      logic                   stable_reg;
      logic                   off_ch_reg;
      logic                   agree;

      // ----------------------------------------
      // channel synchroniser
      // ----------------------------------------
      // three stages; a change counts once stages two and three agree  (see R13)
      always_ff @(posedge mclk_in)
      begin
        if (sys_rst_in)
          sync_reg <= 3'h7;
        else if (clk_en_in)
          sync_reg <= {sync_reg[1:0], raw_in[gi]};
      end

      // the first stage is read only by the second
      assign agree = (sync_reg[1] == sync_reg[2]);

      // reset level is on, so reset alone raises no cutoff
      always_ff @(posedge mclk_in)
      begin
        if (sys_rst_in)
          stable_reg <= 1'h1;
        else if (clk_en_in && agree)
          stable_reg <= sync_reg[2];
      end

      // ----------------------------------------
      // channel off filter
      // ----------------------------------------
      // off time counter; holds at the limit  (see R11)
      always_ff @(posedge mclk_in)
      begin
        if (sys_rst_in)
          filt_cnt_reg <= '0;
        else if (clk_en_in)
        begin
          if (stable_reg)
            filt_cnt_reg <= '0;
          else if (filt_cnt_reg < FILT_CYC[`SCFM_CNT_W-1:0])
            filt_cnt_reg <= filt_cnt_reg + 1'b1;
        end
      end

      // off counts only beyond 0.5 ms; return to on is immediate  (see R11)
      always_ff @(posedge mclk_in)
      begin
        if (sys_rst_in)
          off_ch_reg <= 1'h0;
        else if (clk_en_in)
        begin
          if (stable_reg)
            off_ch_reg <= 1'h0; // see R10
          else if (filt_cnt_reg >= FILT_CYC[`SCFM_CNT_W-1:0])
            off_ch_reg <= 1'h1;
        end
      end

      assign off_reg[gi] = off_ch_reg;
    end
  endgenerate

  // ----------------------------------------
  // channel combination
  // ----------------------------------------
  logic both_off;
  logic any_off;
  logic one_off;
  // a single channel off never reaches the feedback  (see R13)
  assign both_off = off_reg[0] & off_reg[1];
  assign any_off  = off_reg[0] | off_reg[1];
  assign one_off  = off_reg[0] ^ off_reg[1];

  // ----------------------------------------
  // feedback monitor
  // ----------------------------------------
  // registered so a filter edge cannot glitch the pin
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
      link.feedback_monitor_out <= 1'h0;
    else if (clk_en_in)
      link.feedback_monitor_out <= both_off; // see R1, see R2
  end

  // ----------------------------------------
  // cutoff display and torque permission
  // ----------------------------------------
  // open connector reads as both off  (see R8)
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
      cutoff_display_out <= 1'h0;
    else if (clk_en_in)
      cutoff_display_out <= any_off; // see R6, see R8
  end

  // motor current allowed only while both channels are on
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
      torque_enable_out <= 1'h0;
    else if (clk_en_in)
      torque_enable_out <= ~any_off; // see R6, see R8
  end

  // ----------------------------------------
  // input state monitor
  // ----------------------------------------
  // bit set means that channel is on
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
      safety_input_state_monitor_out <= 2'h0;
    else if (clk_en_in)
      safety_input_state_monitor_out <= ~off_reg; // see R7
  end

  // ----------------------------------------
  // channel skew timer and alarm
  // ----------------------------------------
  // not a safety path: a diagnostic for broken wiring
  logic [`SCFM_CNT_W-1:0] skew_cnt_reg;
  logic                   skew_due;
  assign skew_due = one_off && (skew_cnt_reg >= SKEW_CYC[`SCFM_CNT_W-1:0]);

  // saturates at the window so a long hold cannot wrap to zero
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
      skew_cnt_reg <= '0;
    else if (clk_en_in)
    begin
      if (!one_off)
        skew_cnt_reg <= '0;
      else if (skew_cnt_reg < SKEW_CYC[`SCFM_CNT_W-1:0])
        skew_cnt_reg <= skew_cnt_reg + 1'b1;
    end
  end

  // sticky; set wins over clear  (see R12)
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
      input_timing_alarm_out <= 1'h0;
    else if (clk_en_in)
    begin
      if (skew_due)
        input_timing_alarm_out <= 1'h1;
      else if (alarm_clear_in)
        input_timing_alarm_out <= 1'h0;
    end
  end

endmodule

// >>> design/scfm_unit.sv
// safety unit side: drives the cutoff inputs from the guard, checks feedback
`timescale 1ns/1ps
`include "scfm_params.svh"
module scfm_unit
(
  // clock, reset, enable
  input  wire logic mclk_in,
  input  wire logic sys_rst_in,
  input  wire logic clk_en_in,
  // link
  scfm_link_if.unit link,
  // guard side
  input  wire logic guard_open_in,
  output logic      fault_out,
  output logic      run_permit_out
);

  // ----------------------------------------
  // feedback and guard synchronisers
  // ----------------------------------------
  logic [2:0] fb_sync_reg;
  logic [2:0] gd_sync_reg;
  logic       fb_reg;
  logic       guard_reg;
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      fb_sync_reg <= 3'h0;
      gd_sync_reg <= 3'h7;
    end
    else if (clk_en_in)
    begin
      fb_sync_reg <= {fb_sync_reg[1:0], link.feedback_monitor_out}; // see R9
      gd_sync_reg <= {gd_sync_reg[1:0], guard_open_in};
    end
  end
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      fb_reg    <= 1'h0;
      guard_reg <= 1'h1;
    end
    else if (clk_en_in)
    begin
      if (fb_sync_reg[1] == fb_sync_reg[2])
        fb_reg <= fb_sync_reg[2];
      if (gd_sync_reg[1] == gd_sync_reg[2])
        guard_reg <= gd_sync_reg[2];
    end
  end

  // ----------------------------------------
  // guard sequence
  // ----------------------------------------
  scfm_pkg::scfm_unit_state_t state_reg;
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
      state_reg <= scfm_pkg::SCFM_OPEN;
    else if (clk_en_in)
    begin
      case (state_reg)
        scfm_pkg::SCFM_RUN:
          if (guard_reg)
            state_reg <= scfm_pkg::SCFM_OPEN; // see R3
        scfm_pkg::SCFM_OPEN:
          if (!guard_reg)
            state_reg <= scfm_pkg::SCFM_WAIT_CLOSE;
        scfm_pkg::SCFM_WAIT_CLOSE:
          if (guard_reg)
            state_reg <= scfm_pkg::SCFM_OPEN;
          else if (fb_reg)
            state_reg <= scfm_pkg::SCFM_RUN; // see R4
          else
            state_reg <= scfm_pkg::SCFM_FAULT; // see R5
        scfm_pkg::SCFM_FAULT:
          if (guard_reg && fb_reg)
            state_reg <= scfm_pkg::SCFM_OPEN;
        default:
          state_reg <= scfm_pkg::SCFM_OPEN;
      endcase
    end
  end

  // ----------------------------------------
  // outputs; inputs on only while running
  // ----------------------------------------
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      link.safety_input_a_n <= 1'h0;
      link.safety_input_b_n <= 1'h0;
      fault_out             <= 1'h0;
      run_permit_out        <= 1'h0;
    end
    else if (clk_en_in)
    begin
      link.safety_input_a_n <= (state_reg == scfm_pkg::SCFM_RUN) && !guard_reg; // see R10
      link.safety_input_b_n <= (state_reg == scfm_pkg::SCFM_RUN) && !guard_reg;
      fault_out             <= (state_reg == scfm_pkg::SCFM_FAULT);
      run_permit_out        <= (state_reg == scfm_pkg::SCFM_RUN);
    end
  end

endmodule

// >>> testbench/scfm_link_chk.sv
// checker on the safety link between unit and device
`timescale 1ns/1ps
module scfm_link_chk
#(
  parameter int FILT = 20
)
(
  // clock, reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  // link
  input wire logic safety_input_a_n,
  input wire logic safety_input_b_n,
  input wire logic feedback_monitor_out
);
  localparam int LAT = FILT + 10;
  wire logic off2 = !safety_input_a_n && !safety_input_b_n;
  wire logic on1  = safety_input_a_n || safety_input_b_n;
  wire logic fb   = feedback_monitor_out;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);
  sequence s_off_held;
    off2 [*8];
  endsequence
  AST_FB_CAUSE: assert property ($rose(fb) |-> off2 && $past(off2, FILT))
    else $error("feedback rose without both inputs off");
  AST_FB_LATE: assert property ($fell(on1) |-> ##[1:LAT] (fb || on1))
    else $error("feedback did not follow both inputs off");
  AST_FB_HELD: assert property (s_off_held |-> ##[0:LAT] (fb || on1))
    else $error("feedback missing while both inputs off");
  AST_FB_FILTER: assert property ($fell(on1) |-> !fb [*8])
    else $error("feedback came before the off filter ran out");
  AST_FB_DROP: assert property ($rose(on1) |-> ##[1:8] (!fb || off2))
    else $error("feedback did not drop after inputs back on");
  AST_FB_BOTH_ON: assert property ((safety_input_a_n && safety_input_b_n) [*8] |-> !fb)
    else $error("feedback on while both inputs on");
  AST_FB_FALL_CAUSE: assert property ($fell(fb) |-> $past(on1))
    else $error("feedback fell with both inputs off");
  AST_FB_KEEP: assert property (fb && off2 |=> fb)
    else $error("feedback glitched off");
endmodule

// >>> testbench/test_safety_cutoff_feedback_monitor.sv
// testbench: unit and device joined, second device driven directly
`timescale 1ns/1ps
module test_safety_cutoff_feedback_monitor;
  localparam int FILT = 20;
  localparam int SKEW = 200;
  logic       mclk_in = 1'b0;
  logic       sys_rst_in = 1'b1;
  logic       guard_open_in = 1'b1;
  logic       alarm_clear_in = 1'b0;
  logic       fault, run, tq, disp, alm, tq2, disp2, alm2;
  logic [1:0] mon, mon2;
  int         errors = 0;
  int         check_count = 0;
  scfm_link_if link ();
  scfm_link_if link2 ();
  always #4 mclk_in = ~mclk_in;
  scfm_device #(.SKEW_CYC(SKEW), .FILT_CYC(FILT)) scfm_device_inst (.mclk_in, .sys_rst_in, .clk_en_in(1'b1),
    .link(link), .alarm_clear_in, .torque_enable_out(tq), .cutoff_display_out(disp),
    .safety_input_state_monitor_out(mon), .input_timing_alarm_out(alm));
  scfm_device #(.SKEW_CYC(SKEW), .FILT_CYC(FILT)) scfm_device_inst2 (.mclk_in, .sys_rst_in, .clk_en_in(1'b1),
    .link(link2), .alarm_clear_in, .torque_enable_out(tq2), .cutoff_display_out(disp2),
    .safety_input_state_monitor_out(mon2), .input_timing_alarm_out(alm2));
  scfm_unit scfm_unit_inst (.mclk_in, .sys_rst_in, .clk_en_in(1'b1), .link(link), .guard_open_in,
    .fault_out(fault), .run_permit_out(run));
  scfm_link_chk #(.FILT(FILT)) scfm_link_chk_inst (.mclk_in, .sys_rst_in,
    .safety_input_a_n(link.safety_input_a_n), .safety_input_b_n(link.safety_input_b_n),
    .feedback_monitor_out(link.feedback_monitor_out));
  task automatic check(input logic [4:0] seen, input logic [4:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_in);
  endtask
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic wait_run(input logic v);
    for (int i = 0; i < 400 && run !== v; i++) cyc(1);
    if (run !== v)
    begin
      errors++;
      report_and_stop();
    end
  endtask
  task automatic set2(input logic a, input logic b, input int n);
    link2.safety_input_a_n <= a;
    link2.safety_input_b_n <= b;
    cyc(n);
  endtask
  task automatic guard(input logic g, input int n);
    guard_open_in <= g;
    cyc(n);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    logic [1:0] v;
    link2.safety_input_a_n <= 1'b1;
    link2.safety_input_b_n <= 1'b1;
    cyc(6);
    sys_rst_in <= 1'b0;
    guard(1'b1, FILT + 30);
    check({link.feedback_monitor_out, fault, tq, disp, run}, 5'h12);
    guard(1'b0, 0);
    wait_run(1'b1);
    cyc(10);
    check({fault, tq, disp, run, link.feedback_monitor_out}, 5'h0a);
    check({link.feedback_monitor_out, mon, link.safety_input_a_n, link.safety_input_b_n}, 5'h0f);
    $display("test run done");
    guard(1'b1, FILT + 30);
    check({link.feedback_monitor_out, mon, tq, disp}, 5'h11);
    guard(1'b0, 0);
    wait_run(1'b1);
    $display("test reopen done");
    guard(1'b1, 5);
    guard(1'b0, FILT + 30);
    check({fault, run, tq, alm, 1'b0}, 5'h10);
    guard(1'b1, FILT + 30);
    guard(1'b0, 0);
    wait_run(1'b1);
    cyc(10);
    check({fault, run, tq, alm, 1'b0}, 5'h0c);
    $display("test fault done");
    for (int i = 0; i < 4; i++)
    begin
      v = i[1:0];
      set2(v[1], v[0], FILT + 30);
      check({link2.feedback_monitor_out, mon2, tq2, disp2}, {v == 2'b00, v[0], v[1], v == 2'b11, v != 2'b11});
    end
    check({alm2, 4'h0}, 5'h00);
    $display("test table done");
    set2(1'b0, 1'b0, FILT - 1);
    check({link2.feedback_monitor_out, disp2, tq2, 2'b00}, 5'h04);
    set2(1'b1, 1'b1, FILT + 10);
    check({link2.feedback_monitor_out, disp2, tq2, 2'b00}, 5'h04);
    $display("test pulse done");
    set2(1'b0, 1'b1, SKEW + 40);
    check({alm2, 4'h0}, 5'h10);
    set2(1'b1, 1'b1, 10);
    alarm_clear_in <= 1'b1;
    cyc(3);
    alarm_clear_in <= 1'b0;
    cyc(3);
    check({alm2, alm, 3'h0}, 5'h00);
    $display("test alarm done");
    report_and_stop();
  end
endmodule
